// [plls_pkg.sv]
// constants, register map and helpers for the pll configuration and power-down bank
//
// How it works
// - synth mode bit resets 0, selects crystal-only
// - pump current code resets 100b, 110-880 uA
// - series resistor code resets 01b
// - parallel capacitor code resets 01b, 40-200 pF
// - second pole bit resets 1, higher resistor
// - lock accuracy bit resets 1, 16 ppm
// - lock override resets 0, automatic lock
// - vco select resets 1, first oscillator
// - two 5-bit manual codes, 01011b and 00000b
// - crystal doubler off bit resets 0
// - two input disable bits reset 0
// - eight output disable bits reset 0
// - digital loop disable bit resets 0
// - calibration hold bit resets 0
// - reserved bits written zero, read undefined
package plls_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register addresses on the serial register port
  localparam int              PLLS_NREG      = 9;
  localparam logic [15:0]     PLLS_ADDR_LOOP = 16'h00AC;  // pll_loop_filter_setup
  localparam logic [15:0]     PLLS_ADDR_LOCK = 16'h00AD;  // pll_lock_mode_setup
  localparam logic [15:0]     PLLS_ADDR_FIRST_OSCILLATOR = 16'h00AE;  // vco_one_manual_lock
  localparam logic [15:0]     PLLS_ADDR_SECOND_OSCILLATOR = 16'h00AF;  // vco_two_manual_lock
  localparam logic [15:0]     PLLS_ADDR_SPAR = 16'h00B4;  // power_down_spare
  localparam logic [15:0]     PLLS_ADDR_INDI = 16'h00B5;  // input_disable
  localparam logic [15:0]     PLLS_ADDR_FIXD = 16'h00B6;  // power_down_fixed
  localparam logic [15:0]     PLLS_ADDR_OUTD = 16'h00B7;  // output_disable
  localparam logic [15:0]     PLLS_ADDR_BLKD = 16'h00B8;  // pll_block_disable

  // storage indices, packed image index 0 is the lowest address
  localparam logic [3:0]      PLLS_IDX_LOOP  = 4'h0;
  localparam logic [3:0]      PLLS_IDX_LOCK  = 4'h1;
  localparam logic [3:0]      PLLS_IDX_FIRST_OSCILLATOR  = 4'h2;
  localparam logic [3:0]      PLLS_IDX_SECOND_OSCILLATOR  = 4'h3;
  localparam logic [3:0]      PLLS_IDX_SPAR  = 4'h4;
  localparam logic [3:0]      PLLS_IDX_INDI  = 4'h5;
  localparam logic [3:0]      PLLS_IDX_FIXD  = 4'h6;
  localparam logic [3:0]      PLLS_IDX_OUTD  = 4'h7;
  localparam logic [3:0]      PLLS_IDX_BLKD  = 4'h8;

  ////////////////////////////////////////////////////////////////////////////////
  // field defaults
  localparam logic [2:0]      PLLS_PUMP_DEF  = 3'h4;
  localparam logic [1:0]      PLLS_RES_DEF   = 2'h1;
  localparam logic [1:0]      PLLS_CAP_DEF   = 2'h1;
  localparam logic            PLLS_POLE_DEF  = 1'h1;
  localparam logic            PLLS_SYN_DEF   = 1'h0;
  localparam logic            PLLS_ACC_DEF   = 1'h1;
  localparam logic            PLLS_OVR_DEF   = 1'h0;
  localparam logic            PLLS_VSEL_DEF  = 1'h1;
  localparam logic [4:0]      PLLS_CODE1_DEF = 5'h0B;
  localparam logic [4:0]      PLLS_CODE2_DEF = 5'h00;
  localparam logic            PLLS_DBL_DEF   = 1'h0;
  localparam logic [1:0]      PLLS_INOFF_DEF = 2'h0;
  localparam logic [7:0]      PLLS_OUTOFF_DEF = 8'h00;
  localparam logic            PLLS_DLOFF_DEF = 1'h0;
  localparam logic            PLLS_CAL_DEF   = 1'h0;
  localparam logic            PLLS_ONE       = 1'h1;  // fixed-one positions

  ////////////////////////////////////////////////////////////////////////////////
  // field positions inside their registers
  localparam int              PLLS_PUMP_LSB  = 5;
  localparam int              PLLS_RES_LSB   = 3;
  localparam int              PLLS_CAP_LSB   = 1;
  localparam int              PLLS_POLE_BIT  = 0;
  localparam int              PLLS_SYN_BIT   = 3;
  localparam int              PLLS_ACC_BIT   = 1;
  localparam int              PLLS_OVR_BIT   = 0;
  localparam int              PLLS_VSEL_BIT  = 5;
  localparam int              PLLS_DBL_BIT   = 0;
  localparam int              PLLS_DLOFF_BIT = 2;
  localparam int              PLLS_CAL_BIT   = 0;

  // writable bits per register, reserved bits stay zero
  localparam logic [PLLS_NREG-1:0][7:0] PLLS_MASK =
    {8'h0F, 8'hFF, 8'h10, 8'h0F, 8'h01, 8'h1F, 8'h3F, 8'h0B, 8'hFF};

  // reset image built from the field defaults
  localparam logic [PLLS_NREG-1:0][7:0] PLLS_RESET_IMG = {
    {4'h0, PLLS_ONE, PLLS_DLOFF_DEF, PLLS_ONE, PLLS_CAL_DEF},
    PLLS_OUTOFF_DEF,
    {3'h0, PLLS_ONE, 4'h0},
    {4'h0, PLLS_ONE, PLLS_ONE, PLLS_INOFF_DEF},
    {7'h00, PLLS_DBL_DEF},
    {3'h0, PLLS_CODE2_DEF},
    {2'h0, PLLS_VSEL_DEF, PLLS_CODE1_DEF},
    {4'h0, PLLS_SYN_DEF, 1'h0, PLLS_ACC_DEF, PLLS_OVR_DEF},
    {PLLS_PUMP_DEF, PLLS_RES_DEF, PLLS_CAP_DEF, PLLS_POLE_DEF}};

  // address decode: {hit, index}
  function automatic logic [4:0] plls_decode(input logic [15:0] addr);
    logic [4:0] r;
    r = 5'h00;
    case (addr)
      PLLS_ADDR_LOOP: r = {1'h1, PLLS_IDX_LOOP};
      PLLS_ADDR_LOCK: r = {1'h1, PLLS_IDX_LOCK};
      PLLS_ADDR_FIRST_OSCILLATOR: r = {1'h1, PLLS_IDX_FIRST_OSCILLATOR};
      PLLS_ADDR_SECOND_OSCILLATOR: r = {1'h1, PLLS_IDX_SECOND_OSCILLATOR};
      PLLS_ADDR_SPAR: r = {1'h1, PLLS_IDX_SPAR};
      PLLS_ADDR_INDI: r = {1'h1, PLLS_IDX_INDI};
      PLLS_ADDR_FIXD: r = {1'h1, PLLS_IDX_FIXD};
      PLLS_ADDR_OUTD: r = {1'h1, PLLS_IDX_OUTD};
      PLLS_ADDR_BLKD: r = {1'h1, PLLS_IDX_BLKD};
      default:        r = 5'h00;
    endcase
    return r;
  endfunction

endpackage

// [plls_cfg_if.sv]
// write path and stored image shared between the bank and its top
interface plls_cfg_if;
  import plls_pkg::*;
  logic                           wrEn;    // one-cycle write strobe
  logic [15:0]                    addr;    // register address
  logic [7:0]                     wrData;  // write data
  logic [PLLS_NREG-1:0][7:0]      image;   // stored register contents

  modport top  (output wrEn, output addr, output wrData, input image);
  modport bank (input wrEn, input addr, input wrData, output image);
endinterface

// [plls_reg_bank.sv]
// storage for the nine configuration and power-down registers
module plls_reg_bank (
  input  wire logic  clk,
  input  wire logic  rst_n,
  plls_cfg_if.bank   cfg
);
  import plls_pkg::*;

  // whole state of the bank
  typedef struct packed {
    logic [PLLS_NREG-1:0][7:0] regs;  // masked register image
  } plls_bank_s;

  plls_bank_s cur_q;  // registered state
  plls_bank_s nxt_d;  // next state
  logic [4:0] dec;    // decoded write address

  ////////////////////////////////////////////////////////////////////////////////
  // next state: masked store on a mapped write
  always_comb begin
    nxt_d = cur_q;
    dec   = plls_decode(cfg.addr);
    if (cfg.wrEn && dec[4]) begin
      // reserved bits are dropped so they never read back as ones
      nxt_d.regs[dec[3:0]] = cfg.wrData & PLLS_MASK[dec[3:0]];
    end
  end

  // state register, synchronous reset to the listed defaults
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur_q.regs <= PLLS_RESET_IMG;
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign cfg.image = cur_q.regs;

endmodule

// [plls_config_regs.sv]
// top of the pll configuration and power-down register bank
module plls_config_regs (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         regWrEn,
  input  wire logic         regRdEn,
  input  wire logic [15:0]  regAddr,
  input  wire logic [7:0]   regWrData,
  output logic      [7:0]   regRdData,
  output logic              regRdHit,
  output logic      [2:0]   pumpCurrentCode,
  output logic      [1:0]   seriesResistorCode,
  output logic      [1:0]   parallelCapCode,
  output logic              secondPoleSelect,
  output logic              synthOnlySelect,
  output logic              lockCountAccuracy,
  output logic              lockOverride,
  output logic              manualVcoSelect,
  output logic      [4:0]   vcoOneLockCode,
  output logic      [4:0]   vcoTwoLockCode,
  output logic              activeVcoIsFirst,
  output logic      [4:0]   activeLockCode,
  output logic              crystalDoublerOff,
  output logic      [1:0]   inputRefOff,
  output logic      [7:0]   outputOff,
  output logic              digitalLoopOff,
  output logic              apllCalHold
);
  import plls_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // read-side state

  // whole state of the read port
  typedef struct packed {
    logic [7:0] rdData;  // data returned one cycle after the strobe
    logic       rdHit;   // address of that read was mapped
  } plls_rd_s;

  plls_rd_s                  rd_q;   // registered state
  plls_rd_s                  rd_d;   // next state
  logic [4:0]                rdDec;  // decoded read address
  logic [PLLS_NREG-1:0][7:0] img;    // stored image from the bank

  plls_cfg_if cfg ();

  // write path goes straight to the bank, no extra latency
  assign cfg.wrEn   = regWrEn;
  assign cfg.addr   = regAddr;
  assign cfg.wrData = regWrData;
  assign img        = cfg.image;

  // storage bank
  plls_reg_bank u_bank (
    .clk   (clk),
    .rst_n (rst_n),
    .cfg   (cfg)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // read port

  // registered read: an unmapped address returns zero and no hit
  always_comb begin
    rd_d  = rd_q;
    rdDec = plls_decode(regAddr);
    if (regRdEn) begin
      if (rdDec[4]) begin
        // reserved positions hold zero, stricter than needed
        rd_d.rdData = img[rdDec[3:0]];
        rd_d.rdHit  = 1'h1;
      end else begin
        rd_d.rdData = 8'h00;
        rd_d.rdHit  = 1'h0;
      end
    end
  end

  // read state register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_q <= '0;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign regRdData = rd_q.rdData;
  assign regRdHit  = rd_q.rdHit;

  ////////////////////////////////////////////////////////////////////////////////
  // analog pll fields, straight from flops in the bank except the muxed active lock code

  // charge pump, 110 uA per code step above 110 uA
  assign pumpCurrentCode    = img[PLLS_IDX_LOOP][PLLS_PUMP_LSB+:3];
  // loop filter series resistor
  assign seriesResistorCode = img[PLLS_IDX_LOOP][PLLS_RES_LSB+:2];
  // loop filter parallel capacitor
  assign parallelCapCode    = img[PLLS_IDX_LOOP][PLLS_CAP_LSB+:2];
  // second pole: 1 picks the higher post resistor
  assign secondPoleSelect   = img[PLLS_IDX_LOOP][PLLS_POLE_BIT];

  // synthesizer mode; the free-run force lives in another block
  assign synthOnlySelect    = img[PLLS_IDX_LOCK][PLLS_SYN_BIT];
  // lock count: 0 is 1 ppm, 1 is 16 ppm
  assign lockCountAccuracy  = img[PLLS_IDX_LOCK][PLLS_ACC_BIT];
  // 1 hands lock control to the manual codes
  assign lockOverride       = img[PLLS_IDX_LOCK][PLLS_OVR_BIT];

  // manual vco choice, 1 is the first oscillator
  assign manualVcoSelect    = img[PLLS_IDX_FIRST_OSCILLATOR][PLLS_VSEL_BIT];
  assign vcoOneLockCode     = img[PLLS_IDX_FIRST_OSCILLATOR][4:0];
  assign vcoTwoLockCode     = img[PLLS_IDX_SECOND_OSCILLATOR][4:0];

  // manual lock steering: only meaningful while override is set
  always_comb begin
    activeVcoIsFirst = manualVcoSelect;
    if (manualVcoSelect) begin
      activeLockCode = vcoOneLockCode;
    end else begin
      activeLockCode = vcoTwoLockCode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // power-down fields

  // 0 doubles the crystal before the pll
  assign crystalDoublerOff  = img[PLLS_IDX_SPAR][PLLS_DBL_BIT];
  // one disable per input reference
  assign inputRefOff        = img[PLLS_IDX_INDI][1:0];
  // one disable per output, the pad driver floats when set
  assign outputOff          = img[PLLS_IDX_OUTD];
  // digital loop disable
  assign digitalLoopOff     = img[PLLS_IDX_BLKD][PLLS_DLOFF_BIT];
  // holds analog calibration off while set
  assign apllCalHold        = img[PLLS_IDX_BLKD][PLLS_CAL_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // helper: decode of the current address, for readback checks
  logic [4:0] wrDec;
  assign wrDec = plls_decode(regAddr);

  // loop filter defaults after reset
  AST_LOOP_DEFAULTS: assert property (
    !$past(rst_n) |-> (pumpCurrentCode == PLLS_PUMP_DEF)
      && (seriesResistorCode == PLLS_RES_DEF)
      && (parallelCapCode == PLLS_CAP_DEF)
      && (secondPoleSelect == PLLS_POLE_DEF))
    else $error("loop filter fields not at default after reset");

  // mode defaults after reset
  AST_MODE_DEFAULTS: assert property (
    !$past(rst_n) |-> (synthOnlySelect == PLLS_SYN_DEF)
      && (lockCountAccuracy == PLLS_ACC_DEF)
      && (lockOverride == PLLS_OVR_DEF))
    else $error("mode fields not at default after reset");

  // vco defaults after reset
  AST_VCO_DEFAULTS: assert property (
    !$past(rst_n) |-> (manualVcoSelect == PLLS_VSEL_DEF)
      && (vcoOneLockCode == PLLS_CODE1_DEF)
      && (vcoTwoLockCode == PLLS_CODE2_DEF))
    else $error("vco fields not at default after reset");

  // power-down defaults after reset
  AST_PD_DEFAULTS: assert property (
    !$past(rst_n) |-> !crystalDoublerOff && (inputRefOff == PLLS_INOFF_DEF)
      && (outputOff == PLLS_OUTOFF_DEF) && !digitalLoopOff && !apllCalHold)
    else $error("power-down fields not at default after reset");

  // a write to the lock register shows on the synth bit next cycle
  AST_SYNTH_WRITE: assert property (
    regWrEn && (regAddr == PLLS_ADDR_LOCK)
      |=> synthOnlySelect == $past(regWrData[PLLS_SYN_BIT]))
    else $error("synth mode bit did not follow write");

  // output disables follow a write
  AST_OUTOFF_WRITE: assert property (
    regWrEn && (regAddr == PLLS_ADDR_OUTD) |=> outputOff == $past(regWrData))
    else $error("output disables did not follow write");

  // charge pump code follows a loop filter write
  AST_PUMP_WRITE: assert property (
    regWrEn && (regAddr == PLLS_ADDR_LOOP)
      |=> pumpCurrentCode == $past(regWrData[PLLS_PUMP_LSB+:3]))
    else $error("pump current code did not follow write");

  // a mis-sliced field shows here before any read-back does
  AST_RES_WRITE: assert property (
    regWrEn && (regAddr == PLLS_ADDR_LOOP)
      |=> seriesResistorCode == $past(regWrData[PLLS_RES_LSB+:2]))
    else $error("series resistor code did not follow write");

  // parallel capacitor code follows a loop filter write
  AST_CAP_WRITE: assert property (
    regWrEn && (regAddr == PLLS_ADDR_LOOP)
      |=> parallelCapCode == $past(regWrData[PLLS_CAP_LSB+:2]))
    else $error("parallel capacitor code did not follow write");

  // second pole bit follows a loop filter write
  AST_POLE_WRITE: assert property (
    regWrEn && (regAddr == PLLS_ADDR_LOOP)
      |=> secondPoleSelect == $past(regWrData[PLLS_POLE_BIT]))
    else $error("second pole bit did not follow write");

  // lock accuracy bit follows a lock register write
  AST_ACC_WRITE: assert property (
    regWrEn && (regAddr == PLLS_ADDR_LOCK)
      |=> lockCountAccuracy == $past(regWrData[PLLS_ACC_BIT]))
    else $error("lock accuracy bit did not follow write");

  // lock override follows a lock register write
  AST_OVR_WRITE: assert property (
    regWrEn && (regAddr == PLLS_ADDR_LOCK)
      |=> lockOverride == $past(regWrData[PLLS_OVR_BIT]))
    else $error("lock override did not follow write");

  // vco select follows a write to the first code register
  AST_VSEL_WRITE: assert property (
    regWrEn && (regAddr == PLLS_ADDR_FIRST_OSCILLATOR)
      |=> manualVcoSelect == $past(regWrData[PLLS_VSEL_BIT]))
    else $error("vco select did not follow write");

  // first manual code follows its write
  AST_CODE1_WRITE: assert property (
    regWrEn && (regAddr == PLLS_ADDR_FIRST_OSCILLATOR)
      |=> vcoOneLockCode == $past(regWrData[4:0]))
    else $error("first lock code did not follow write");

  // second manual code follows its write
  AST_CODE2_WRITE: assert property (
    regWrEn && (regAddr == PLLS_ADDR_SECOND_OSCILLATOR)
      |=> vcoTwoLockCode == $past(regWrData[4:0]))
    else $error("second lock code did not follow write");

  // crystal doubler bit follows its write
  AST_DBL_WRITE: assert property (
    regWrEn && (regAddr == PLLS_ADDR_SPAR)
      |=> crystalDoublerOff == $past(regWrData[PLLS_DBL_BIT]))
    else $error("crystal doubler bit did not follow write");

  // input disables follow their write
  AST_INREF_WRITE: assert property (
    regWrEn && (regAddr == PLLS_ADDR_INDI)
      |=> inputRefOff == $past(regWrData[1:0]))
    else $error("input disables did not follow write");

  // digital loop disable follows its write
  AST_DLOFF_WRITE: assert property (
    regWrEn && (regAddr == PLLS_ADDR_BLKD)
      |=> digitalLoopOff == $past(regWrData[PLLS_DLOFF_BIT]))
    else $error("digital loop disable did not follow write");

  // calibration hold follows its write
  AST_CAL_WRITE: assert property (
    regWrEn && (regAddr == PLLS_ADDR_BLKD)
      |=> apllCalHold == $past(regWrData[PLLS_CAL_BIT]))
    else $error("calibration hold did not follow write");

  // write then read back returns the masked value
  AST_READBACK: assert property (
    regWrEn && wrDec[4] ##1 (regRdEn && !regWrEn && regAddr == $past(regAddr))
      |=> regRdData == ($past(regWrData, 2) & PLLS_MASK[$past(wrDec[3:0], 2)]))
    else $error("read back does not match written value");

  // without a write the stored image holds
  AST_HOLD: assert property (
    !regWrEn |=> $stable(img))
    else $error("register image changed without a write");

  // reserved bits of the lock, first oscillator and block disable registers never become set
  AST_RSVD_ZERO: assert property (
    (img[PLLS_IDX_LOCK] & ~PLLS_MASK[PLLS_IDX_LOCK]) == 8'h00
      && (img[PLLS_IDX_FIRST_OSCILLATOR] & ~PLLS_MASK[PLLS_IDX_FIRST_OSCILLATOR]) == 8'h00
      && (img[PLLS_IDX_BLKD] & ~PLLS_MASK[PLLS_IDX_BLKD]) == 8'h00)
    else $error("reserved bit set in register image");

  // unmapped reads answer zero with no hit
  AST_UNMAPPED: assert property (
    regRdEn && !rdDec[4] |=> !regRdHit && regRdData == 8'h00)
    else $error("unmapped read returned data or hit");

  // manual code follows the vco choice
  AST_ACTIVE_CODE: assert property (
    activeLockCode == (manualVcoSelect ? vcoOneLockCode : vcoTwoLockCode))
    else $error("active lock code does not follow vco select");

  // read data holds until the next read
  AST_RD_STABLE: assert property (
    !regRdEn |=> $stable(regRdData) && $stable(regRdHit))
    else $error("read data changed without a read");

  // scenarios worth seeing
  COV_SYNTH_ON: cover property (
    regWrEn && regAddr == PLLS_ADDR_LOCK && regWrData[PLLS_SYN_BIT] ##1 synthOnlySelect);
  COV_MANUAL_SECOND: cover property (lockOverride && !manualVcoSelect);
  COV_ALL_OUT_OFF: cover property (outputOff == 8'hFF);
  COV_UNMAPPED_RD: cover property (regRdEn && !rdDec[4]);

endmodule

// [test_pll_config_powerdown_regs.sv]
// self-checking testbench for the pll configuration and power-down register bank
module test_pll_config_powerdown_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import plls_pkg::*;

  // one compare: counts it, reports a mismatch at once
  `define CHK(nm, exp, got) begin numChecks++; if ((got) !== (exp)) begin mismatches++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end

  //////////////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic        clk;                 // 200 MHz clock
  logic        rst_n;               // synchronous reset, active low
  logic        regWrEn;             // write strobe
  logic        regRdEn;             // read strobe
  logic [15:0] regAddr;             // register address
  logic [7:0]  regWrData;           // write data
  logic [7:0]  regRdData;           // read data
  logic        regRdHit;            // read address was mapped
  logic [2:0]  pumpCurrentCode;     // field outputs follow
  logic [1:0]  seriesResistorCode;
  logic [1:0]  parallelCapCode;
  logic        secondPoleSelect;
  logic        synthOnlySelect;
  logic        lockCountAccuracy;
  logic        lockOverride;
  logic        manualVcoSelect;
  logic [4:0]  vcoOneLockCode;
  logic [4:0]  vcoTwoLockCode;
  logic        activeVcoIsFirst;
  logic [4:0]  activeLockCode;
  logic        crystalDoublerOff;
  logic [1:0]  inputRefOff;
  logic [7:0]  outputOff;
  logic        digitalLoopOff;
  logic        apllCalHold;
  int          mismatches;          // failed compares
  int          numChecks;           // compares made
  int          cycles;              // clock cycles since start
  logic [7:0]  expv [9];            // expected contents, one byte per register

  // register table: address, reset value, readable bits, bits with a field output
  localparam logic [15:0] ADDRS [9] = '{16'h00AC, 16'h00AD, 16'h00AE, 16'h00AF, 16'h00B4,
                                        16'h00B5, 16'h00B6, 16'h00B7, 16'h00B8};
  localparam logic [7:0]  DEFS  [9] = '{8'h8B, 8'h02, 8'h2B, 8'h00, 8'h00, 8'h0C, 8'h10,
                                        8'h00, 8'h0A};
  localparam logic [7:0]  RMSK  [9] = '{8'hFF, 8'h0B, 8'h3F, 8'h1F, 8'h01, 8'h0F, 8'h10,
                                        8'hFF, 8'h0F};
  localparam logic [7:0]  FMSK  [9] = '{8'hFF, 8'h0B, 8'h3F, 8'h1F, 8'h01, 8'h03, 8'h00,
                                        8'hFF, 8'h05};
  // fixed-one positions that software keeps set on every write
  localparam logic [7:0]  FIXO  [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0C, 8'h10,
                                        8'h00, 8'h0A};

  plls_config_regs i_dut (
    .clk(clk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdHit(regRdHit),
    .pumpCurrentCode(pumpCurrentCode), .seriesResistorCode(seriesResistorCode),
    .parallelCapCode(parallelCapCode), .secondPoleSelect(secondPoleSelect),
    .synthOnlySelect(synthOnlySelect), .lockCountAccuracy(lockCountAccuracy),
    .lockOverride(lockOverride), .manualVcoSelect(manualVcoSelect),
    .vcoOneLockCode(vcoOneLockCode), .vcoTwoLockCode(vcoTwoLockCode),
    .activeVcoIsFirst(activeVcoIsFirst), .activeLockCode(activeLockCode),
    .crystalDoublerOff(crystalDoublerOff), .inputRefOff(inputRefOff),
    .outputOff(outputOff), .digitalLoopOff(digitalLoopOff), .apllCalHold(apllCalHold));

  // clock: half period of 2.5 ns
  always #2.5 clk = ~clk;

  // hang guard: the whole run needs about 150 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      $display("[FAIL] run limit reached after %0d cycles", cycles);
      finish_test();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  // rebuild a register byte from the field outputs, so fields are judged at the pins
  function automatic logic [7:0] outImg(input int i);
    case (i)
      0:       return {pumpCurrentCode, seriesResistorCode, parallelCapCode, secondPoleSelect};
      1:       return {4'h0, synthOnlySelect, 1'h0, lockCountAccuracy, lockOverride};
      2:       return {2'h0, manualVcoSelect, vcoOneLockCode};
      3:       return {3'h0, vcoTwoLockCode};
      4:       return {7'h00, crystalDoublerOff};
      5:       return {6'h00, inputRefOff};
      7:       return outputOff;
      8:       return {5'h00, digitalLoopOff, 1'h0, apllCalHold};
      default: return 8'h00;
    endcase
  endfunction

  // step to just after the next rising edge
  task automatic cyc();
    @(posedge clk);
    #1;
  endtask

  // strobes stay up between back-to-back requests so no signal toggles twice in a step
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    regRdEn   = 1'h0;
    regAddr   = a;
    regWrData = d;
    regWrEn   = 1'h1;
    cyc();
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic hit);
    regWrEn = 1'h0;
    regAddr = a;
    regRdEn = 1'h1;
    cyc();
    `CHK("read data", exp, regRdData)
    `CHK("read hit", hit, regRdHit)
  endtask

  task automatic idle();
    regWrEn = 1'h0;
    regRdEn = 1'h0;
    cyc();
  endtask

  // write one register and track what it must hold afterwards
  task automatic wrReg(input int i, input logic [7:0] d);
    wr(ADDRS[i], d);
    expv[i] = d & RMSK[i];
  endtask

  // every field output and every read-back against the tracked contents
  task automatic check_all();
    for (int i = 0; i < 9; i++) begin
      `CHK("field outputs", expv[i] & FMSK[i], outImg(i))
      rd(ADDRS[i], expv[i], 1'h1);
    end
    idle();
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // scenarios
  // defaults straight after reset, before any request
  task automatic test_defaults();
    expv = DEFS;
    check_all();
    check_all();
  endtask

  // back-to-back writes of several patterns; reserved bits must read as dropped
  task automatic test_walk();
    logic [7:0] pats [4];
    pats = '{8'hFF, 8'h00, 8'hA5, 8'h5A};
    for (int p = 0; p < 4; p++) begin
      for (int i = 0; i < 9; i++) wrReg(i, pats[p] | FIXO[i]);
      check_all();
    end
  endtask

  // unmapped places, upper address byte too: no hit, no data, nothing disturbed
  task automatic test_unmapped();
    logic [15:0] bad [4];
    bad = '{16'h00AB, 16'h00B0, 16'h00B9, 16'h01AC};
    for (int k = 0; k < 4; k++) begin
      wr(bad[k], 8'hFF);
      rd(bad[k], 8'h00, 1'h0);
    end
    check_all();
  endtask

  // synth mode set, field changes next cycle, read follows right behind
  task automatic test_synth();
    // free-run is taken as already forced in the loop block outside this bank
    wrReg(1, 8'h08);
    `CHK("synth select", 1'h1, synthOnlySelect)
    rd(ADDRS[1], 8'h08, 1'h1);
    idle();
  endtask

  // manual oscillator choice steers the active lock code
  task automatic test_vco_mux();
    // large loop capacitor assumed, so the accuracy bit goes low
    wrReg(1, 8'h01);
    wrReg(2, 8'h31);
    wrReg(3, 8'h0E);
    `CHK("override", 1'h1, lockOverride)
    `CHK("first vco", 1'h1, activeVcoIsFirst)
    `CHK("active code", 5'h11, activeLockCode)
    wrReg(2, 8'h11);
    `CHK("first vco", 1'h0, activeVcoIsFirst)
    `CHK("active code", 5'h0E, activeLockCode)
    idle();
  endtask

  // read and write of one register in the same cycle: read sees the old byte
  task automatic test_same_cycle();
    regAddr   = 16'h00AF;
    regWrData = 8'h15;
    regWrEn   = 1'h1;
    regRdEn   = 1'h1;
    cyc();
    `CHK("old read", 8'h0E, regRdData)
    `CHK("new code", 5'h15, vcoTwoLockCode)
    expv[3] = 8'h15;
    idle();
  endtask

  // reset in mid-run brings every register and the read port back to defaults
  task automatic test_midreset();
    for (int i = 0; i < 9; i++) wrReg(i, 8'hFF);
    rd(ADDRS[0], 8'hFF, 1'h1);
    idle();
    rst_n = 1'h0;
    cyc();
    rst_n = 1'h1;
    `CHK("read data reset", 8'h00, regRdData)
    `CHK("read hit reset", 1'h0, regRdHit)
    expv = DEFS;
    check_all();
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // closing report, the single exit of the run
  task automatic finish_test();
    $display("checks made %0d, mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    clk        = 1'h0;
    rst_n      = 1'h0;
    regWrEn    = 1'h0;
    regRdEn    = 1'h0;
    regAddr    = 16'h0000;
    regWrData  = 8'h00;
    mismatches = 0;
    numChecks  = 0;
    cycles     = 0;
    repeat (3) cyc();
    rst_n = 1'h1;
    test_defaults();
    test_walk();
    test_unmapped();
    test_synth();
    test_vco_mux();
    test_same_cycle();
    test_midreset();
    finish_test();
  end
endmodule
